// File: include/spf_pkg.sv
`default_nettype none
package spf_pkg;

    // ---------------------------------------------------------------
    // Array geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 7;
    localparam int OFS_W = 4;
    localparam int MEM_BYTES = 2048;
    localparam int PAGES = 128;
    localparam int PAGE_BYTES = 16;
    localparam logic [4:0] MAX_WR_BYTES = 5'h10;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ---------------------------------------------------------------
    // Command byte fields
    // ---------------------------------------------------------------
    localparam int CMD_FIXED_BIT = 7;
    localparam int CMD_SEL_HIGH_BIT = 6;
    localparam int CMD_SEL_MID_BIT = 5;
    localparam int CMD_SEL_LOW_BIT = 4;
    localparam int CMD_UPPER_MSB = 3;
    localparam int CMD_UPPER_LSB = 1;
    localparam int CMD_RW_BIT = 0;

    // ---------------------------------------------------------------
    // Timing and buffering
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_US = 8000;
    localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 32;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } spf_wr_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_RACK = 5'h10
    } spf_bus_e;

    typedef enum logic [3:0] {
        PG_IDLE = 4'h1,
        PG_ERASE = 4'h2,
        PG_WRITE = 4'h4,
        PG_WAIT = 4'h8
    } spf_prog_e;

endpackage
`default_nettype wire

// File: logic/spf_eeprom.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Serial data bits are captured on the rising serial clock edge.
// - Read data on the data line changes only on falling clock edges.
// - Data line is open drain: it only pulls low or releases.
// - Three select straps pick one of 8 devices; others are ignored.
// - Protect pin low allows normal writes, gated only by page bits.
// - Protect pin high blocks every change to stored contents.
// - A set page protection bit blocks changes to that page.
// - Store holds 2048 bytes as 128 pages of 16 bytes.
// - Separate 128-bit protection store, one bit per page.
// - Master sets a page's protection bit over the bus, no pin toggling.
// - Each programming operation is self timed: erase first, then write.
// - One operation modifies 1 to 16 bytes; further data bytes are not acknowledged.
// - Command byte: fixed one, selects with middle inverted, upper address, read flag.
// - Programming starts on the stop condition after written data.
// - Each erase and write cycle ends within 8 ms.

// ---------------------------------------------------------------
// Write buffer
// ---------------------------------------------------------------
module spf_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_ff [DEPTH];
    logic [PW:0] wr_ptr_ff;
    logic [PW:0] rd_ptr_ff;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty
    assign in_ready = (wr_ptr_ff - rd_ptr_ff) != (PW+1)'(DEPTH);
    assign out_valid = wr_ptr_ff != rd_ptr_ff;
    assign out_data = buf_ff[rd_ptr_ff[PW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            buf_ff[wr_ptr_ff[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule

// ---------------------------------------------------------------
// Serial EEPROM slave front end
// ---------------------------------------------------------------
module spf_eeprom
    import spf_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Two-wire bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and protection
    input wire logic select_strap_low,
    input wire logic select_strap_mid,
    input wire logic select_strap_high,
    input wire logic wp,
    // Status
    output logic busy
);
    logic [7:0] mem_ff [MEM_BYTES];
    logic [PAGES-1:0] prot_ff;
    spf_bus_e st_ff;
    spf_prog_e pg_ff;
    logic scl_q_ff;
    logic sda_q_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [1:0] stage_ff;
    logic is_read_ff;
    logic ack_ff;
    logic ack_on_ff;
    logic sda_oe_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [4:0] wr_cnt_ff;
    logic wr_op_ff;
    logic [PAGE_W-1:0] op_page_ff;
    logic busy_ff;
    logic [16:0] timer_ff;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rx_byte;
    logic selected;
    logic fifo_in_valid;
    logic fifo_in_ready;
    spf_wr_s fifo_in;
    logic fifo_out_valid;
    logic fifo_out_ready;
    spf_wr_s fifo_out;
    logic prog_go;
    logic may_change;
    logic timer_done;

    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        // Write pointer rolls over inside its page
        page_inc = {a[ADDR_W-1:OFS_W], a[OFS_W-1:0] + 1'b1};
    endfunction

    function automatic logic page_open(input logic [PAGE_W-1:0] pg,
                                       input logic [PAGES-1:0] pr,
                                       input logic wp_pin);
        page_open = ~wp_pin & ~pr[pg];
    endfunction

    // ---------------------------------------------------------------
    // Pin sampling and bus conditions
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl;
            sda_q_ff <= sda_in;
        end
    end

    assign scl_rise = scl & ~scl_q_ff;
    assign scl_fall = ~scl & scl_q_ff;
    assign start_seen = scl & scl_q_ff & sda_q_ff & ~sda_in;
    assign stop_seen = scl & scl_q_ff & ~sda_q_ff & sda_in;
    assign rx_byte = {shift_ff[6:0], sda_in};
    assign selected = rx_byte[CMD_FIXED_BIT]
        & (rx_byte[CMD_SEL_HIGH_BIT] == select_strap_high)
        & (rx_byte[CMD_SEL_MID_BIT] == ~select_strap_mid)
        & (rx_byte[CMD_SEL_LOW_BIT] == select_strap_low);

    // Open drain: the driven level is always low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_ff;
    assign busy = busy_ff;

    // ---------------------------------------------------------------
    // Bus state machine
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            shift_ff <= '0;
            stage_ff <= '0;
            is_read_ff <= 1'b0;
            ack_ff <= 1'b0;
            ack_on_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (start_seen) begin
            st_ff <= ST_RX;
            bit_cnt_ff <= '0;
            stage_ff <= '0;
            ack_on_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (stop_seen) begin
            st_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_ff <= rx_byte;
                        bit_cnt_ff <= bit_cnt_ff + 1'b1;
                        if (bit_cnt_ff == LAST_BIT) begin
                            bit_cnt_ff <= '0;
                            st_ff <= ST_ACK;
                            if (stage_ff != 2'h3) begin
                                stage_ff <= stage_ff + 1'b1;
                            end
                            if (stage_ff == 2'h0) begin
                                // Busy parts stay silent so the master can poll
                                ack_ff <= selected & ~busy_ff;
                                is_read_ff <= rx_byte[CMD_RW_BIT];
                                if (~selected | busy_ff) begin
                                    st_ff <= ST_IDLE;
                                end
                            end else if (is_read_ff) begin
                                ack_ff <= 1'b0;
                            end else if (stage_ff == 2'h1) begin
                                ack_ff <= 1'b1;
                            end else begin
                                ack_ff <= fifo_in_valid & fifo_in_ready;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (~ack_on_ff) begin
                            ack_on_ff <= 1'b1;
                            sda_oe_ff <= ack_ff;
                        end else begin
                            ack_on_ff <= 1'b0;
                            if (~ack_ff) begin
                                sda_oe_ff <= 1'b0;
                                st_ff <= ST_IDLE;
                            end else if (is_read_ff) begin
                                shift_ff <= mem_ff[addr_ff];
                                sda_oe_ff <= ~mem_ff[addr_ff][7];
                                st_ff <= ST_TX;
                            end else begin
                                sda_oe_ff <= 1'b0;
                                st_ff <= ST_RX;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 1'b1;
                    end
                    if (scl_fall) begin
                        if (bit_cnt_ff == BYTE_BITS) begin
                            bit_cnt_ff <= '0;
                            sda_oe_ff <= 1'b0;
                            st_ff <= ST_RACK;
                        end else begin
                            sda_oe_ff <= ~shift_ff[6];
                            shift_ff <= {shift_ff[6:0], 1'b1};
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        ack_on_ff <= ~sda_in;
                        if (sda_in) begin
                            st_ff <= ST_IDLE;
                        end
                    end
                    if (scl_fall & ack_on_ff) begin
                        ack_on_ff <= 1'b0;
                        shift_ff <= mem_ff[addr_ff];
                        sda_oe_ff <= ~mem_ff[addr_ff][7];
                        st_ff <= ST_TX;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Address counter and write collection
    // ---------------------------------------------------------------
    assign fifo_in_valid = (st_ff == ST_RX) & scl_rise & (bit_cnt_ff == LAST_BIT)
        & ~is_read_ff & (stage_ff[1]) & (wr_cnt_ff != MAX_WR_BYTES);
    assign fifo_in.addr = addr_ff;
    assign fifo_in.data = rx_byte;

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_ff <= '0;
            wr_cnt_ff <= '0;
            wr_op_ff <= 1'b0;
            op_page_ff <= '0;
        end else if (start_seen) begin
            wr_op_ff <= 1'b0;
            wr_cnt_ff <= '0;
        end else if (stop_seen) begin
            wr_op_ff <= 1'b0;
        end else if ((st_ff == ST_RX) & scl_rise & (bit_cnt_ff == LAST_BIT)) begin
            if ((stage_ff == 2'h0) & selected & ~rx_byte[CMD_RW_BIT]) begin
                addr_ff[ADDR_W-1:8] <= rx_byte[CMD_UPPER_MSB:CMD_UPPER_LSB];
            end else if ((stage_ff == 2'h1) & ~is_read_ff) begin
                addr_ff[7:0] <= rx_byte;
                op_page_ff <= {addr_ff[ADDR_W-1:8], rx_byte[7:OFS_W]};
                wr_op_ff <= 1'b1;
            end else if (fifo_in_valid & fifo_in_ready) begin
                addr_ff <= page_inc(addr_ff);
                wr_cnt_ff <= wr_cnt_ff + 1'b1;
            end
        end else if ((st_ff == ST_ACK) & scl_fall & ack_on_ff & ack_ff & is_read_ff) begin
            addr_ff <= addr_ff + 1'b1;
        end else if ((st_ff == ST_RACK) & scl_fall & ack_on_ff) begin
            addr_ff <= addr_ff + 1'b1;
        end
    end

    spf_fifo #(
        .WIDTH($bits(spf_wr_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // ---------------------------------------------------------------
    // Self-timed programming
    // ---------------------------------------------------------------
    assign prog_go = stop_seen & wr_op_ff & ~busy_ff;
    assign may_change = page_open(fifo_out.addr[ADDR_W-1:OFS_W], prot_ff, wp);
    // Drain stalls during the erase step
    assign fifo_out_ready = (pg_ff == PG_WRITE);
    assign timer_done = timer_ff >= 17'(PROG_CYC - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            pg_ff <= PG_IDLE;
            busy_ff <= 1'b0;
            timer_ff <= '0;
        end else begin
            unique case (pg_ff)
                PG_IDLE: begin
                    timer_ff <= '0;
                    if (prog_go) begin
                        busy_ff <= 1'b1;
                        pg_ff <= fifo_out_valid ? PG_ERASE : PG_WAIT;
                    end
                end
                PG_ERASE: begin
                    timer_ff <= timer_ff + 1'b1;
                    pg_ff <= PG_WRITE;
                end
                PG_WRITE: begin
                    timer_ff <= timer_ff + 1'b1;
                    pg_ff <= PG_WAIT;
                end
                PG_WAIT: begin
                    if (~timer_done) begin
                        timer_ff <= timer_ff + 1'b1;
                    end
                    if (fifo_out_valid) begin
                        pg_ff <= PG_ERASE;
                    end else if (timer_done) begin
                        busy_ff <= 1'b0;
                        pg_ff <= PG_IDLE;
                    end
                end
            endcase
        end
    end

    // Blocked bytes are dropped silently; the bus already acknowledged them
    always_ff @(posedge clk) begin
        if ((pg_ff == PG_ERASE) & may_change) begin
            mem_ff[fifo_out.addr] <= ERASED_BYTE;
        end else if ((pg_ff == PG_WRITE) & may_change) begin
            mem_ff[fifo_out.addr] <= fifo_out.data;
        end
    end

    // Protection bits only ever set; a data-less write arms its page
    always_ff @(posedge clk) begin
        if (rst) begin
            prot_ff <= '0;
        end else if (prog_go & (wr_cnt_ff == 5'h00) & ~wp) begin
            prot_ff[op_page_ff] <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// File: tb/spf_eeprom_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Pin-level checker
// ---------------------------------------------------------------
module spf_eeprom_checker #(
    parameter int PROG_CYC = 80000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Straps, protection, status
    input wire logic select_strap_low,
    input wire logic select_strap_mid,
    input wire logic select_strap_high,
    input wire logic wp,
    input wire logic busy
);
    int busy_cnt_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Length of the running programming cycle
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            busy_cnt_ff <= 0;
        end else begin
            busy_cnt_ff <= busy_cnt_ff + 1;
        end
    end

    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !sda_oe && !busy)
        else $error("line driven or busy after reset");
    pull_only_a: assert property (sda_out == 1'b0)
        else $error("data output not low");
    fall_edge_drive_a: assert property ($changed(sda_oe) |-> !scl && !$past(scl)
        && ($past(scl, 2) || $past(scl, 3) || $past(scl, 4)))
        else $error("data drive changed away from clock fall");
    steady_high_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    drive_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("drive released too soon");
    busy_limit_a: assert property (busy_cnt_ff <= PROG_CYC)
        else $error("programming cycle too long");
    two_step_a: assert property ($fell(busy) |-> busy_cnt_ff >= 2)
        else $error("programming cycle too short for erase and write");
    busy_after_stop_a: assert property ($rose(busy) |-> scl && sda_in && !sda_oe)
        else $error("programming began without stop");
    busy_silent_a: assert property (busy && $past(busy) |-> !sda_oe)
        else $error("device answered while programming");
endmodule
`default_nettype wire

// File: tb/spf_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Two-wire bus master model
// ---------------------------------------------------------------
module spf_i2c_master (
    // Clock and line
    input wire logic clk,
    input wire logic sda_line,
    // Drives
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Bit phase of 4 clk (a third of a bit) keeps scl steady well past the 2 clk minimum
    task automatic q(input logic c, input logic l);
        scl <= c;
        sda_low <= l;
        repeat (4) @(posedge clk);
    endtask

    // Also serves as repeated start
    task automatic start();
        q(1'b0, 1'b0);
        q(1'b1, 1'b0);
        q(1'b1, 1'b1);
        q(1'b0, 1'b1);
    endtask

    task automatic stop();
        q(1'b0, 1'b1);
        q(1'b1, 1'b1);
        q(1'b1, 1'b0);
    endtask

    // Data moves only while scl is low; line sampled late in the high phase
    task automatic bit_x(input logic b, output logic s);
        q(1'b0, !b);
        q(1'b1, !b);
        s = sda_line;
        q(1'b0, !b);
    endtask

    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
        end
        bit_x(1'b1, s);
        ack = !s;
    endtask

    task automatic rd(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(!ack, s);
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------
module testbench
    import spf_pkg::*;
;
    localparam int PC = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic [2:0] strap = 3'h0;
    logic scl, m_low, sda_out, sda_oe, busy, sda_line;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] mem [MEM_BYTES];
    logic [PAGES-1:0] prot = '0;
    logic [10:0] a0;

    // Pull-up: released line reads high
    assign sda_line = !(m_low || sda_oe);
    always #50 clk = ~clk;

    spf_eeprom #(.PROG_CYC(PC)) u_dut (
        .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .select_strap_low(strap[0]), .select_strap_mid(strap[1]),
        .select_strap_high(strap[2]), .wp(wp), .busy(busy));
    spf_i2c_master u_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic [7:0] cmd(input logic [2:0] s, input logic [2:0] up, input logic rd);
        return {1'b1, s[2], ~s[1], s[0], up, rd};
    endfunction

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Polls while busy, then waits for the cycle to end
    task automatic prog_wait(input logic want);
        logic ack;
        logic seen;
        int n;
        seen = 1'b0;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            if (busy === 1'b1) seen = 1'b1;
        end
        if (want) chk(seen, "no programming cycle");
        if (seen) begin
            u_mst.start();
            u_mst.wr(cmd(strap, 3'h0, 1'b0), ack);
            chk(ack === 1'b0, "command taken while busy");
            u_mst.stop();
        end
        while (busy !== 1'b0 && n < PC + 8) begin
            @(posedge clk);
            n++;
        end
        chk(busy === 1'b0, "programming cycle too long");
    endtask

    task automatic wr_seq(input logic [10:0] a, input int n);
        logic ack;
        logic [7:0] d;
        logic keep;
        keep = wp || prot[a[10:4]];
        u_mst.start();
        u_mst.wr(cmd(strap, a[10:8], 1'b0), ack);
        chk(ack === 1'b1, "write command refused");
        u_mst.wr(a[7:0], ack);
        chk(ack === 1'b1, "address refused");
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_mst.wr(d, ack);
            chk(ack === (i < 16), "data acknowledge");
            if (i < 16 && !keep) mem[{a[10:4], 4'(a[3:0] + i)}] = d;
        end
        if (n == 0 && !wp) prot[a[10:4]] = 1'b1;
        u_mst.stop();
        prog_wait(n > 0 && !keep);
    endtask

    task automatic rd_chk(input logic [10:0] a, input int n);
        logic ack;
        logic [7:0] d;
        u_mst.start();
        u_mst.wr(cmd(strap, a[10:8], 1'b0), ack);
        u_mst.wr(a[7:0], ack);
        u_mst.start();
        u_mst.wr(cmd(strap, 3'h0, 1'b1), ack);
        chk(ack === 1'b1, "read command refused");
        for (int i = 0; i < n; i++) begin
            u_mst.rd(i < n - 1, d);
            chk(d === mem[11'(a + i)], "read data");
        end
        u_mst.stop();
        repeat (8) @(posedge clk);
        chk(busy === 1'b0, "busy after read");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    initial begin
        logic [10:0] a;
        logic ack;
        int n;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(sda_oe === 1'b0 && busy === 1'b0, "reset state");
        void'($urandom(24));
        strap <= 3'($urandom);
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            a = 11'($urandom);
            n = 1 + ($urandom % 16);
            if (k == 0) a[3:0] = 4'h5;
            if (k < 2) n = 16 + k;
            if (k == 0) a0 = a;
            wr_seq(a, n);
            if (n >= 16) rd_chk({a[10:4], 4'h0}, 16);
            else rd_chk(a, (n < 16 - a[3:0]) ? n : 16 - a[3:0]);
        end
        $display("Test page writes done");
        wp <= 1'b1;
        @(posedge clk);
        wr_seq(a0, 3);
        wr_seq(a0, 0);
        rd_chk({a0[10:4], 4'h0}, 16);
        wp <= 1'b0;
        @(posedge clk);
        wr_seq(a0, 2);
        wr_seq(a0, 0);
        wr_seq(a0, 2);
        rd_chk({a0[10:4], 4'h0}, 16);
        wr_seq(a0 ^ 11'h010, 2);
        rd_chk(a0 ^ 11'h010, 2);
        $display("Test protection done");
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            @(posedge clk);
            u_mst.start();
            u_mst.wr(cmd(3'(s + 1), 3'h0, 1'b1), ack);
            chk(ack === 1'b0, "other device answered");
            u_mst.start();
            u_mst.wr(cmd(strap, 3'h0, 1'b1) & 8'h7F, ack);
            chk(ack === 1'b0, "cleared fixed bit accepted");
            u_mst.stop();
            rd_chk(a0, 2);
        end
        $display("Test straps done");
        end_sim();
    end
endmodule

bind spf_eeprom spf_eeprom_checker #(.PROG_CYC(PROG_CYC)) u_chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_strap_low(select_strap_low), .select_strap_mid(select_strap_mid),
    .select_strap_high(select_strap_high), .wp(wp), .busy(busy));
`default_nettype wire
